//--- pkg/dts_pkg.sv
// Package for the dual timer subport access block: register map, field layout and reset values.
// Assumes a single clock domain and the nibble-wide subport protocol of the core.
package dts_pkg;
   // ==========================================================
   // Subaddress map
   localparam logic [3:0] ADDR_TMR0_MODE  = 4'h0;
   localparam logic [3:0] ADDR_TMR0_CTRL  = 4'h1;
   localparam logic [3:0] ADDR_TMR1_MODE  = 4'h2;
   localparam logic [3:0] ADDR_TMR1_CTRL  = 4'h3;
   localparam logic [3:0] ADDR_PAIR_MODE  = 4'h4;
   localparam logic [3:0] ADDR_PIN_ROUTE  = 4'h5;
   localparam logic [3:0] ADDR_PIN_DIR    = 4'h6;
   localparam logic [3:0] ADDR_RESERVED   = 4'h7;
   localparam logic [3:0] ADDR_TMR1_BYTE  = 4'h8;
   localparam logic [3:0] ADDR_TMR0_BYTE  = 4'h9;
   // ==========================================================
   // Reset values
   localparam logic [3:0] MODE_RESET      = 4'hF;
   localparam logic [3:0] CTRL_RESET      = 4'hF;
   localparam logic [3:0] NIB_RESET       = 4'hF;
   localparam logic [7:0] MATCH_RESET     = 8'hFF;
   // ==========================================================
   // Clock control fields: bits 2:0 pick the source, bit 3 masks the interrupt.
   localparam int CTRL_SRC_LSB            = 0;
   localparam int CTRL_SRC_MSB            = 2;
   localparam int CTRL_IRQ_MASK_BIT       = 3;
   // Pair mode fields: bit 0 cascades, bit 1 runs timer 0, bit 2 runs timer 1.
   localparam int PAIR_CASCADE_BIT        = 0;
   localparam int PAIR_RUN0_BIT           = 1;
   localparam int PAIR_RUN1_BIT           = 2;
   // Timer 0 modes whose low bit is set are free running; clear means reload.
   localparam int MODE_FREE_BIT           = 0;
   // Source code that selects the core system clock.
   localparam logic [2:0] SRC_CORE_CLOCK  = 3'h7;
   localparam int NUM_SOURCES             = 8;
   // ==========================================================
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] data;
   } dts_port_s;
   typedef enum logic {
      DTS_LOW_NIB,
      DTS_HIGH_NIB
   } dts_nib_e;
endpackage

//--- rtl/dts_top.sv
// Dual 8-bit timer/counter with prescalers behind an indirect subaddress and data port.
// Assumes port strobes are one-cycle pulses synchronous to core_clk_in; clock sources are synchronous levels.
`timescale 1ns/10ps
module dts_top #(
   parameter int PRESCALE_W = 8
) (
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   input  wire dts_pkg::dts_port_s subaddress_port_in,
   input  wire dts_pkg::dts_port_s data_port_in,
   input  wire logic [6:0]        clk_src_in,
   input  wire logic              core_sleep_in,
   input  wire logic              tmr0_pin_in,
   output logic [3:0]             rd_data_out,
   output logic                   tmr1_irq_out,
   output logic                   tmr0_irq_out,
   output logic [3:0]             pin_direction_out,
   output logic                   tmr0_pin_out,
   output logic                   tmr0_pin_oe_out
);
   import dts_pkg::*;

   // ==========================================================
   // Register access
   // The subaddress and both nibble pointers live here; the core sees only nibbles.
   // A byte compare value is staged in low_hold_reg so the timer never sees half of it.
   logic [3:0] sub_reg, sub_next;
   dts_nib_e   wr_nib_reg, wr_nib_next, rd_nib_reg, rd_nib_next;
   logic [3:0] tmr0_mode_sel_reg, tmr0_mode_sel_next;
   logic [3:0] tmr0_clock_ctrl_reg, tmr0_clock_ctrl_next;
   logic [3:0] tmr1_mode_sel_reg, tmr1_mode_sel_next;
   logic [3:0] tmr1_clock_ctrl_reg, tmr1_clock_ctrl_next;
   logic [3:0] pair_mode_ctrl_reg, pair_mode_ctrl_next;
   logic [3:0] pin_route_ctrl_reg, pin_route_ctrl_next;
   logic [3:0] pin_direction_ctrl_reg, pin_direction_ctrl_next;
   logic [7:0] tmr0_match_value_reg, tmr0_match_value_next;
   logic [7:0] tmr1_match_value_reg, tmr1_match_value_next;
   logic [3:0] low_hold_reg, low_hold_next;
   logic       cmp0_busy_reg, cmp0_busy_next;
   logic       cmp1_busy_reg, cmp1_busy_next;
   logic [7:0] snap_hold_reg, snap_hold_next;
   logic [3:0] rd_data_reg, rd_data_next;
   logic [7:0] cnt0_reg, cnt1_reg;

   always_comb begin
      sub_next               = sub_reg;
      wr_nib_next            = wr_nib_reg;
      rd_nib_next            = rd_nib_reg;
      tmr0_mode_sel_next     = tmr0_mode_sel_reg;
      tmr0_clock_ctrl_next   = tmr0_clock_ctrl_reg;
      tmr1_mode_sel_next     = tmr1_mode_sel_reg;
      tmr1_clock_ctrl_next   = tmr1_clock_ctrl_reg;
      pair_mode_ctrl_next    = pair_mode_ctrl_reg;
      pin_route_ctrl_next    = pin_route_ctrl_reg;
      pin_direction_ctrl_next = pin_direction_ctrl_reg;
      tmr0_match_value_next  = tmr0_match_value_reg;
      tmr1_match_value_next  = tmr1_match_value_reg;
      low_hold_next          = low_hold_reg;
      cmp0_busy_next         = cmp0_busy_reg;
      cmp1_busy_next         = cmp1_busy_reg;
      snap_hold_next         = snap_hold_reg;
      rd_data_next           = rd_data_reg;
      if (subaddress_port_in.wr) begin
         // A fresh subaddress restarts both nibble sequences.
         sub_next    = subaddress_port_in.data;
         wr_nib_next = DTS_LOW_NIB;
         rd_nib_next = DTS_HIGH_NIB;
      end else if (data_port_in.wr) begin
         case (sub_reg)
            ADDR_TMR0_MODE: tmr0_mode_sel_next      = data_port_in.data;
            ADDR_TMR0_CTRL: tmr0_clock_ctrl_next    = data_port_in.data;
            ADDR_TMR1_MODE: tmr1_mode_sel_next      = data_port_in.data;
            ADDR_TMR1_CTRL: tmr1_clock_ctrl_next    = data_port_in.data;
            ADDR_PAIR_MODE: pair_mode_ctrl_next     = data_port_in.data;
            ADDR_PIN_ROUTE: pin_route_ctrl_next     = data_port_in.data;
            ADDR_PIN_DIR:   pin_direction_ctrl_next = data_port_in.data;
            ADDR_TMR1_BYTE, ADDR_TMR0_BYTE: begin
               if (wr_nib_reg == DTS_LOW_NIB) begin
                  low_hold_next = data_port_in.data;
                  wr_nib_next   = DTS_HIGH_NIB;
                  if (sub_reg == ADDR_TMR1_BYTE) begin
                     cmp1_busy_next = 1'b1;
                  end else begin
                     cmp0_busy_next = 1'b1;
                  end
               end else begin
                  wr_nib_next = DTS_LOW_NIB;
                  if (sub_reg == ADDR_TMR1_BYTE) begin
                     tmr1_match_value_next = {data_port_in.data, low_hold_reg};
                     cmp1_busy_next        = 1'b0;
                  end else begin
                     tmr0_match_value_next = {data_port_in.data, low_hold_reg};
                     cmp0_busy_next        = 1'b0;
                  end
               end
            end
            default: ;
         endcase
      end else if (data_port_in.rd) begin
         // The byte is frozen on the high read so both halves belong to one sample.
         if (sub_reg == ADDR_TMR1_BYTE || sub_reg == ADDR_TMR0_BYTE) begin
            if (rd_nib_reg == DTS_HIGH_NIB) begin
               snap_hold_next = (sub_reg == ADDR_TMR1_BYTE) ? cnt1_reg : cnt0_reg;
               rd_data_next   = snap_hold_next[7:4];
               rd_nib_next    = DTS_LOW_NIB;
            end else begin
               rd_data_next = snap_hold_reg[3:0];
               rd_nib_next  = DTS_HIGH_NIB;
            end
         end else begin
            // Reads at other subaddresses leave both pointers untouched.
            rd_data_next = 4'h0;
         end
      end
   end

   // Reset leaves every control nibble at all ones: sources on the core clock, interrupts masked.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sub_reg                <= 4'h0;
         wr_nib_reg             <= DTS_LOW_NIB;
         rd_nib_reg             <= DTS_HIGH_NIB;
         tmr0_mode_sel_reg      <= MODE_RESET;
         tmr0_clock_ctrl_reg    <= CTRL_RESET;
         tmr1_mode_sel_reg      <= MODE_RESET;
         tmr1_clock_ctrl_reg    <= CTRL_RESET;
         pair_mode_ctrl_reg     <= NIB_RESET;
         pin_route_ctrl_reg     <= NIB_RESET;
         pin_direction_ctrl_reg <= NIB_RESET;
         tmr0_match_value_reg   <= MATCH_RESET;
         tmr1_match_value_reg   <= MATCH_RESET;
         low_hold_reg           <= 4'h0;
         cmp0_busy_reg          <= 1'b0;
         cmp1_busy_reg          <= 1'b0;
         snap_hold_reg          <= 8'h00;
         rd_data_reg            <= 4'h0;
      end else begin
         sub_reg                <= sub_next;
         wr_nib_reg             <= wr_nib_next;
         rd_nib_reg             <= rd_nib_next;
         tmr0_mode_sel_reg      <= tmr0_mode_sel_next;
         tmr0_clock_ctrl_reg    <= tmr0_clock_ctrl_next;
         tmr1_mode_sel_reg      <= tmr1_mode_sel_next;
         tmr1_clock_ctrl_reg    <= tmr1_clock_ctrl_next;
         pair_mode_ctrl_reg     <= pair_mode_ctrl_next;
         pin_route_ctrl_reg     <= pin_route_ctrl_next;
         pin_direction_ctrl_reg <= pin_direction_ctrl_next;
         tmr0_match_value_reg   <= tmr0_match_value_next;
         tmr1_match_value_reg   <= tmr1_match_value_next;
         low_hold_reg           <= low_hold_next;
         cmp0_busy_reg          <= cmp0_busy_next;
         cmp1_busy_reg          <= cmp1_busy_next;
         snap_hold_reg          <= snap_hold_next;
         rd_data_reg            <= rd_data_next;
      end
   end

   // ==========================================================
   // Clock selection and prescalers
   // Source 7 is the core clock itself, seen as a constant-high enable that sleep removes.
   // Sources 0 to 6 are sampled levels; a rising edge is one tick, so each needs a low phase.
   // A source faster than half the core clock loses ticks, which the user must avoid.
   logic [NUM_SOURCES-1:0] src_vec;
   logic [2:0]             src0_sel, src1_sel;
   logic                   src0_lvl, src1_lvl;
   logic                   src0_prev_reg, src0_prev_next, src1_prev_reg, src1_prev_next;
   logic                   tick0_raw, tick1_raw;
   logic [PRESCALE_W-1:0]  pre0_reg, pre0_next, pre1_reg, pre1_next;
   logic                   step0, step1;

   always_comb begin
      src_vec  = {~core_sleep_in, clk_src_in};
      src0_sel = tmr0_clock_ctrl_reg[CTRL_SRC_MSB:CTRL_SRC_LSB];
      src1_sel = tmr1_clock_ctrl_reg[CTRL_SRC_MSB:CTRL_SRC_LSB];
      src0_lvl = src_vec[src0_sel];
      src1_lvl = src_vec[src1_sel];
      src0_prev_next = src0_lvl;
      src1_prev_next = src1_lvl;
      // The core clock source ticks on every cycle it is running; others count rising edges.
      tick0_raw = (src0_sel == SRC_CORE_CLOCK) ? src0_lvl : (src0_lvl & ~src0_prev_reg);
      tick1_raw = (src1_sel == SRC_CORE_CLOCK) ? src1_lvl : (src1_lvl & ~src1_prev_reg);
      // Only the divide ratio is programmable through the mode nibble's bit 3; the chain is fixed.
      pre0_next = tick0_raw ? pre0_reg + 1'b1 : pre0_reg;
      pre1_next = tick1_raw ? pre1_reg + 1'b1 : pre1_reg;
      // Mode bit 3 clear halves the rate by stepping only on odd prescaler counts.
      // Upper prescaler bits are kept so a longer divide chain can reuse them later.
      step0 = tick0_raw & pair_mode_ctrl_reg[PAIR_RUN0_BIT] &
              (tmr0_mode_sel_reg[3] ? 1'b1 : (pre0_reg[0] == 1'b1));
      step1 = tick1_raw & pair_mode_ctrl_reg[PAIR_RUN1_BIT] &
              (tmr1_mode_sel_reg[3] ? 1'b1 : (pre1_reg[0] == 1'b1));
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src0_prev_reg <= 1'b0;
         src1_prev_reg <= 1'b0;
         pre0_reg      <= '0;
         pre1_reg      <= '0;
      end else begin
         src0_prev_reg <= src0_prev_next;
         src1_prev_reg <= src1_prev_next;
         pre0_reg      <= pre0_next;
         pre1_reg      <= pre1_next;
      end
   end

   // ==========================================================
   // Counters and interrupts
   // Timer 1 always reloads on its match; timer 0 reloads only in reload modes.
   // The interrupt pulses last one cycle; the core is expected to latch them itself.
   // A compare written while busy still lets the counter run; only the interrupt waits.
   logic [7:0] cnt0_next, cnt1_next;
   logic       cascade, free0, ovf0, match0, match1, adv1;
   logic       irq0_next, irq1_next, pin_next, pin_reg, oe_next, oe_reg;
   logic [3:0] dir_next, dir_reg;

   always_comb begin
      cascade = pair_mode_ctrl_reg[PAIR_CASCADE_BIT];
      free0   = tmr0_mode_sel_reg[MODE_FREE_BIT];
      match0  = step0 & (cnt0_reg == tmr0_match_value_reg);
      ovf0    = step0 & (cnt0_reg == 8'hFF);
      cnt0_next = cnt0_reg;
      if (step0) begin
         cnt0_next = (!free0 && match0) ? 8'h00 : cnt0_reg + 8'h01;
      end
      // Cascaded, timer 1 advances on timer 0 overflow to form one 16-bit count.
      adv1    = cascade ? ovf0 : step1;
      match1  = adv1 & (cnt1_reg == tmr1_match_value_reg);
      cnt1_next = cnt1_reg;
      if (adv1) begin
         cnt1_next = match1 ? 8'h00 : cnt1_reg + 8'h01;
      end
      irq1_next = match1 & ~tmr1_clock_ctrl_reg[CTRL_IRQ_MASK_BIT] & ~cmp1_busy_reg;
      irq0_next = (free0 ? ovf0 : match0) & ~tmr0_clock_ctrl_reg[CTRL_IRQ_MASK_BIT] &
                  ~cmp0_busy_reg;
      pin_next  = match0 ? ~pin_reg : pin_reg;
      // With routing bit 0 clear, timer 0 mode bit 2 sets the pin enable, drives direction bit 1 to its inverse, and sets direction bit 0 when it is set;
      // with mode bit 2 clear, direction bit 0 follows the inverted tmr0_pin_in. Otherwise the port direction applies.
      oe_next   = pin_route_ctrl_reg[0] ? 1'b0 : tmr0_mode_sel_reg[2];
      dir_next  = pin_direction_ctrl_reg;
      if (!pin_route_ctrl_reg[0]) begin
         dir_next[1] = ~tmr0_mode_sel_reg[2];
         dir_next[0] = tmr0_mode_sel_reg[2] ? 1'b1 : ~tmr0_pin_in;
      end
   end

   // The pin toggles on timer 0 match only; its enable is timer 0 mode bit 2 while routing bit 0 is clear, and off while it is set.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt0_reg     <= 8'h00;
         cnt1_reg     <= 8'h00;
         tmr0_irq_out <= 1'b0;
         tmr1_irq_out <= 1'b0;
         pin_reg      <= 1'b0;
         oe_reg       <= 1'b0;
         dir_reg      <= NIB_RESET;
      end else begin
         cnt0_reg     <= cnt0_next;
         cnt1_reg     <= cnt1_next;
         tmr0_irq_out <= irq0_next;
         tmr1_irq_out <= irq1_next;
         pin_reg      <= pin_next;
         oe_reg       <= oe_next;
         dir_reg      <= dir_next;
      end
   end

   // ==========================================================
   // Outputs
   // Every output is a plain copy of a register, so no logic lies between flip-flop and pin.
   assign rd_data_out       = rd_data_reg;
   assign tmr0_pin_out      = pin_reg;
   assign tmr0_pin_oe_out   = oe_reg;
   assign pin_direction_out = dir_reg;
endmodule

//--- bench/dts_core_model.sv
// Core-side model that drives the subaddress and data ports of the timer block.
// Assumes the core clock is shared; the bench calls these tasks hierarchically.
`timescale 1ns/10ps
module dts_core_model (
   input  wire logic          clk_in,
   input  wire logic [3:0]    rd_data_in,
   output dts_pkg::dts_port_s sub_out,
   output dts_pkg::dts_port_s dat_out
);
   import dts_pkg::*;
   initial begin
      sub_out = '0;
      dat_out = '0;
   end
   // ==========================================================
   // Port cycles
   // Released data lines show the inverse so a stale value can never pass.
   task automatic put_sub(input logic [3:0] a, input logic clash);
      @(posedge clk_in);
      sub_out <= '{wr: 1'b1, rd: 1'b0, data: a};
      dat_out.rd <= clash;
      @(posedge clk_in);
      sub_out <= '{wr: 1'b0, rd: 1'b0, data: ~a};
      dat_out.rd <= 1'b0;
   endtask
   task automatic put_nib(input logic [3:0] d);
      @(posedge clk_in);
      dat_out <= '{wr: 1'b1, rd: 1'b0, data: d};
      @(posedge clk_in);
      dat_out <= '{wr: 1'b0, rd: 1'b0, data: ~d};
   endtask
   task automatic get_nib(output logic [3:0] n);
      @(posedge clk_in);
      dat_out.rd <= 1'b1;
      @(posedge clk_in);
      dat_out.rd <= 1'b0;
      #1 n = rd_data_in;
   endtask
   task automatic put_reg(input logic [3:0] a, input logic [3:0] d);
      put_sub(a, 1'b0);
      put_nib(d);
   endtask
   task automatic get_byte(input logic [3:0] a, output logic [7:0] v);
      put_sub(a, 1'b0);
      get_nib(v[7:4]);
      get_nib(v[3:0]);
   endtask
endmodule

//--- bench/dts_top_asserts.sv
// Checker for the port behaviour of the dual timer block.
// Assumes one clock domain; it tracks the subaddress and masks from port writes.
`timescale 1ns/10ps
module dts_top_asserts (
   input wire logic               core_clk_in,
   input wire logic               rst_n_in,
   input wire dts_pkg::dts_port_s subaddress_port_in,
   input wire dts_pkg::dts_port_s data_port_in,
   input wire logic [3:0]         rd_data_out,
   input wire logic               tmr1_irq_out,
   input wire logic               tmr0_irq_out,
   input wire logic [3:0]         pin_direction_out
);
   import dts_pkg::*;
   logic [3:0] sub_reg;
   logic [3:0] sub_next;
   logic       wptr_reg;
   logic       wptr_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic       rd_taken;
   logic       dat_wr;
   assign rd_taken = data_port_in.rd && !data_port_in.wr && !subaddress_port_in.wr;
   assign dat_wr = data_port_in.wr && !subaddress_port_in.wr;
   // ==========================================================
   // Shadow of the port state
   always_comb begin
      sub_next = sub_reg;
      wptr_next = wptr_reg;
      mask_next = mask_reg;
      if (subaddress_port_in.wr) begin
         sub_next = subaddress_port_in.data;
         wptr_next = 1'b0;
      end else if (data_port_in.wr) begin
         if (sub_reg == ADDR_TMR0_CTRL) mask_next[0] = data_port_in.data[CTRL_IRQ_MASK_BIT];
         if (sub_reg == ADDR_TMR1_CTRL) mask_next[1] = data_port_in.data[CTRL_IRQ_MASK_BIT];
         if (sub_reg == ADDR_TMR0_BYTE || sub_reg == ADDR_TMR1_BYTE) wptr_next = !wptr_reg;
      end
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sub_reg <= 4'h0;
         wptr_reg <= 1'b0;
         mask_reg <= 2'h3;
      end else begin
         sub_reg <= sub_next;
         wptr_reg <= wptr_next;
         mask_reg <= mask_next;
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_split(logic [3:0] addr);
      wptr_reg && sub_reg == addr ##1 wptr_reg && sub_reg == addr;
   endsequence
   sequence s_clash;
      data_port_in.rd && (data_port_in.wr || subaddress_port_in.wr);
   endsequence
   a_rd_data_holds: assert property (!$past(rd_taken) |-> $stable(rd_data_out))
      else $error("read nibble changed without a read");
   a_unmapped_zero: assert property (rd_taken && sub_reg < ADDR_TMR1_BYTE |=> rd_data_out == 4'h0)
      else $error("unreadable subaddress gave nonzero data");
   a_clash_ignored: assert property (s_clash |=> $stable(rd_data_out))
      else $error("read taken together with a write");
   a_tmr0_masked: assert property (mask_reg[0] && $past(mask_reg[0]) |-> !tmr0_irq_out)
      else $error("timer 0 interrupt while masked");
   a_tmr1_masked: assert property (mask_reg[1] && $past(mask_reg[1]) |-> !tmr1_irq_out)
      else $error("timer 1 interrupt while masked");
   a_tmr0_split_quiet: assert property (s_split(ADDR_TMR0_BYTE) |-> !tmr0_irq_out)
      else $error("timer 0 interrupt between compare nibbles");
   a_tmr1_split_quiet: assert property (s_split(ADDR_TMR1_BYTE) |-> !tmr1_irq_out)
      else $error("timer 1 interrupt between compare nibbles");
   a_dir_write: assert property (dat_wr && sub_reg == ADDR_PIN_DIR |-> ##2
      pin_direction_out[3:2] == $past(data_port_in.data[3:2], 2))
      else $error("direction write not applied");
endmodule
bind dts_top dts_top_asserts u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .subaddress_port_in(subaddress_port_in), .data_port_in(data_port_in), .rd_data_out(rd_data_out),
   .tmr1_irq_out(tmr1_irq_out), .tmr0_irq_out(tmr0_irq_out), .pin_direction_out(pin_direction_out));

//--- bench/dts_top_test.sv
// Self-checking bench for the dual timer block, driven through the core model.
// Assumes a 50 ns core clock; clock sources come from a free counter.
`timescale 1ns/10ps
module dts_top_test;
   import dts_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   dts_port_s  sub;
   dts_port_s  dat;
   logic [7:0] src_cnt = 8'h00;
   logic [6:0] clk_src = 7'h00;
   logic       sleep = 1'b0;
   logic       pin_in = 1'b0;
   logic [3:0] rd_data;
   logic       irq1;
   logic       irq0;
   logic [3:0] dir;
   logic       tmr0_pin;
   logic       tmr0_oe;
   int         nirq[2] = '{0, 0};
   int         fails = 0;
   int         comparisons = 0;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      src_cnt <= src_cnt + 8'h01;
      clk_src <= src_cnt[6:0];
      pin_in <= src_cnt[3];
   end
   // Pulses are counted mid-cycle so the count never races the edge that launches them.
   always @(negedge clk) begin
      if (irq1 === 1'b1) nirq[0] <= nirq[0] + 1;
      if (irq0 === 1'b1) nirq[1] <= nirq[1] + 1;
   end
   dts_core_model core (.clk_in(clk), .rd_data_in(rd_data), .sub_out(sub), .dat_out(dat));
   dts_top DUT (.core_clk_in(clk), .rst_n_in(rst_n), .subaddress_port_in(sub), .data_port_in(dat),
      .clk_src_in(clk_src), .core_sleep_in(sleep), .tmr0_pin_in(pin_in), .rd_data_out(rd_data),
      .tmr1_irq_out(irq1), .tmr0_irq_out(irq0), .pin_direction_out(dir), .tmr0_pin_out(tmr0_pin),
      .tmr0_pin_oe_out(tmr0_oe));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #4000000;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end
   // ==========================================================
   // Tests
   initial begin
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] c;
      logic [7:0] cv;
      logic [3:0] bs;
      int         base;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1 check({irq1, irq0, tmr0_pin, tmr0_oe, dir}, 8'h0F, "reset outputs");
      core.put_reg(ADDR_PIN_DIR, 4'h5);
      core.put_reg(ADDR_RESERVED, 4'hA);
      #1 check(8'(dir), 8'h05, "direction after reserved write");
      for (int i = 0; i < 8; i++) begin
         core.put_sub(4'(i), 1'b0);
         core.get_nib(a[3:0]);
         check(8'(a[3:0]), 8'h00, "write-only place reads zero");
      end
      $display("test map done");
      // Cascade off so each timer matches on its own compare value.
      core.put_reg(ADDR_PAIR_MODE, 4'h6);
      core.put_reg(ADDR_TMR0_MODE, 4'hC);
      for (int t = 0; t < 2; t++) begin
         bs = t ? ADDR_TMR0_BYTE : ADDR_TMR1_BYTE;
         cv = t ? 8'h21 : 8'h12;
         core.put_reg(t ? ADDR_TMR0_CTRL : ADDR_TMR1_CTRL, 4'h7);
         core.put_sub(bs, 1'b0);
         core.put_nib(cv[3:0]);
         repeat (2) @(posedge clk);
         #1 base = nirq[t];
         repeat (3000) @(posedge clk);
         check(8'(nirq[t] - base), 8'h00, "quiet between nibbles");
         core.put_nib(cv[7:4]);
         for (int i = 0; i < 20000 && nirq[t] == base; i++) @(posedge clk);
         check(8'(nirq[t] != base), 8'h01, "match interrupt");
         sleep <= 1'b1;
         core.get_byte(bs, a);
         check(8'(a == cv || a < 8'h03), 8'h01, "capture near match");
         repeat (600) @(posedge clk);
         core.get_byte(bs, b);
         check(b, a, "count frozen in sleep");
         sleep <= 1'b0;
         core.put_reg(t ? ADDR_TMR0_CTRL : ADDR_TMR1_CTRL, 4'hF);
         repeat (2) @(posedge clk);
         #1 base = nirq[t];
         repeat (3000) @(posedge clk);
         check(8'(nirq[t] - base), 8'h00, "masked timer quiet");
      end
      $display("test timer done");
      sleep <= 1'b1;
      core.put_reg(ADDR_TMR1_CTRL, 4'h8);
      core.get_byte(ADDR_TMR1_BYTE, a);
      repeat (1300) @(posedge clk);
      core.get_byte(ADDR_TMR1_BYTE, b);
      repeat (1300) @(posedge clk);
      core.get_byte(ADDR_TMR1_BYTE, c);
      check(8'(b != a || c != a), 8'h01, "source 0 runs in sleep");
      a = 8'(rd_data);
      core.put_sub(ADDR_TMR0_BYTE, 1'b1);
      #1 check(8'(rd_data), a, "read refused beside subaddress write");
      $display("test source done");
      core.put_reg(ADDR_PIN_DIR, 4'hA);
      core.put_reg(ADDR_PIN_ROUTE, 4'h0);
      repeat (2) @(posedge clk);
      #1 check({3'b000, tmr0_oe, dir}, 8'h19, "timer owns pin direction");
      $display("test pins done");
      test_done();
   end
endmodule
